// ===== fpu_state_registers.sv
`timescale 1ns/1ps
`include "fpu_state_map.svh"
module fpu_state_registers (
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_arst_n,
  // Instruction completion from pipeline
  input  wire logic                        i_valid,
  input  fpu_state_pkg::instr_class_t      i_class,
  input  wire logic [2:0]                  i_top,
  input  wire logic [2:0]                  i_src_rel,
  input  wire logic                        i_src_used,
  input  wire logic                        i_has_mem,
  input  fpu_state_pkg::far_ptr_t          i_instr_ptr,
  input  fpu_state_pkg::far_ptr_t          i_oper_ptr,
  input  wire logic [7:0]                  i_opc_byte1,
  input  wire logic [7:0]                  i_opc_byte2,
  input  wire logic                        i_dst_write,
  input  wire logic [2:0]                  i_dst_rel,
  input  fpu_state_pkg::tag_t              i_dst_tag,
  // Mode for image layout
  input  wire logic                        i_protected,
  input  wire logic                        i_v86,
  input  wire logic                        i_op32,
  // Environment image from memory
  input  wire logic [15:0]                 i_img_tag,
  input  fpu_state_pkg::far_ptr_t          i_img_iptr,
  input  fpu_state_pkg::far_ptr_t          i_img_optr,
  input  fpu_state_pkg::opcode_rec_t       i_img_opc,
  input  wire logic [15:0]                 i_img_cw,
  // Data register contents
  input  fpu_state_pkg::ext_real_t         i_data_reg [8],
  // Stack checks
  output logic                             o_overflow,
  output logic                             o_underflow,
  // Environment image to memory
  output logic                             o_store_env,
  output logic                             o_store_data,
  output logic                             o_load_data,
  output fpu_state_pkg::env_layout_t       o_layout,
  output logic [15:0]                      o_tag_image,
  output fpu_state_pkg::far_ptr_t          o_iptr_image,
  output fpu_state_pkg::far_ptr_t          o_optr_image,
  output fpu_state_pkg::opcode_rec_t       o_opc_image,
  output logic [15:0]                      o_cw_image,
  output logic                             o_inf_ctrl
);
  import fpu_state_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [15:0] register_tag_word_ff;
  far_ptr_t    last_instruction_pointer_ff;
  far_ptr_t    last_operand_pointer_ff;
  opcode_rec_t last_opcode_record_ff;
  logic [15:0] ctrl_word_ff;
  logic        overflow_ff;
  logic        underflow_ff;
  logic        store_env_ff;
  logic        store_data_ff;
  logic        load_data_ff;

  tag_class_if cls_bus ();
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_val
      assign cls_bus.value[g] = i_data_reg[g];
    end
  endgenerate
  tag_classifier u_cls (
    .cls (cls_bus.classifier)
  );
  layout_select u_lay (
    .i_protected (i_protected),
    .i_v86       (i_v86),
    .i_op32      (i_op32),
    .o_layout    (o_layout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  function automatic tag_t tag_at(input logic [15:0] w, input logic [2:0] idx);
    tag_at = w[idx*2 +: 2];
  endfunction

  wire logic       is_init;
  wire logic       is_save;
  wire logic       is_stenv;
  wire logic       is_ldenv;
  wire logic       is_rstor;
  wire logic       is_push;
  wire logic       is_pop;
  wire logic       noncontrol;
  wire logic       clear_all;
  wire logic       env_load;
  wire logic [2:0] push_top;
  wire logic [2:0] pop_top;
  wire logic [2:0] src_phys;
  wire logic [2:0] dst_phys;
  wire logic       ovf_hit;
  wire logic       unf_hit;
  logic [15:0]     reload_tags;
  logic [15:0]     nxt_tag_word;

  assign is_init    = i_valid && i_class == OP_INIT;
  assign is_save    = i_valid && i_class == OP_SAVE;
  assign is_stenv   = i_valid && i_class == OP_STENV;
  assign is_ldenv   = i_valid && i_class == OP_LDENV;
  assign is_rstor   = i_valid && i_class == OP_RSTOR;
  assign is_push    = i_valid && i_class == OP_PUSH;
  assign is_pop     = i_valid && i_class == OP_POP;
  assign noncontrol = i_valid &&
                      (i_class == OP_ARITH || i_class == OP_PUSH || i_class == OP_POP);
  assign clear_all  = is_init || is_save;
  assign env_load   = is_ldenv || is_rstor;
  assign push_top   = i_top - 3'h1;
  assign pop_top    = i_top + 3'h1;
  assign src_phys   = i_top + i_src_rel;
  assign dst_phys   = (is_push ? push_top : i_top) + i_dst_rel;
  assign ovf_hit    = is_push && tag_at(register_tag_word_ff, push_top) != `TAG_EMPTY;
  assign unf_hit    = (is_pop && tag_at(register_tag_word_ff, pop_top) == `TAG_EMPTY) ||
                      (noncontrol && i_src_used &&
                       tag_at(register_tag_word_ff, src_phys) == `TAG_EMPTY);

  generate
    for (g = 0; g < 8; g++) begin : g_reload
      assign reload_tags[g*2 +: 2] = (i_img_tag[g*2 +: 2] == `TAG_EMPTY) ? `TAG_EMPTY
                                     : cls_bus.tag[g];
    end
  endgenerate

  always_comb begin
    nxt_tag_word = register_tag_word_ff;
    if (clear_all) begin
      nxt_tag_word = `TAG_WORD_RESET;
    end else if (env_load) begin
      nxt_tag_word = reload_tags;
    end else if (noncontrol && i_dst_write && !ovf_hit) begin
      nxt_tag_word[dst_phys*2 +: 2] = i_dst_tag;
    end else if (is_pop && !unf_hit) begin
      nxt_tag_word[i_top*2 +: 2] = `TAG_EMPTY;
    end
  end

  wire logic [10:0] nxt_opc;
  assign nxt_opc = {i_opc_byte1[2:0], i_opc_byte2};

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      register_tag_word_ff <= `TAG_WORD_RESET;
    end else begin
      register_tag_word_ff <= nxt_tag_word;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      last_instruction_pointer_ff <= 48'h0;
      last_operand_pointer_ff     <= 48'h0;
      last_opcode_record_ff       <= 11'h000;
    end else if (clear_all) begin
      last_instruction_pointer_ff <= 48'h0;
      last_operand_pointer_ff     <= 48'h0;
      last_opcode_record_ff       <= 11'h000;
    end else if (env_load) begin
      last_instruction_pointer_ff <= i_img_iptr;
      last_operand_pointer_ff     <= i_img_optr;
      last_opcode_record_ff       <= i_img_opc;
    end else if (noncontrol) begin
      last_instruction_pointer_ff <= i_instr_ptr;
      last_opcode_record_ff       <= nxt_opc;
      if (i_has_mem) begin
        last_operand_pointer_ff <= i_oper_ptr;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_word_ff <= `CW_INIT;
    end else if (clear_all) begin
      ctrl_word_ff <= `CW_INIT;
    end else if (env_load) begin
      ctrl_word_ff <= i_img_cw;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      overflow_ff   <= 1'b0;
      underflow_ff  <= 1'b0;
      store_env_ff  <= 1'b0;
      store_data_ff <= 1'b0;
      load_data_ff  <= 1'b0;
    end else begin
      overflow_ff   <= ovf_hit;
      underflow_ff  <= unf_hit;
      store_env_ff  <= is_stenv || is_save;
      store_data_ff <= is_save;
      load_data_ff  <= is_rstor;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_overflow   = overflow_ff;
  assign o_underflow  = underflow_ff;
  assign o_store_env  = store_env_ff;
  assign o_store_data = store_data_ff;
  assign o_load_data  = load_data_ff;
  assign o_tag_image  = register_tag_word_ff;
  assign o_iptr_image = last_instruction_pointer_ff;
  assign o_optr_image = last_operand_pointer_ff;
  assign o_opc_image  = last_opcode_record_ff;
  assign o_cw_image   = ctrl_word_ff;
  assign o_inf_ctrl   = ctrl_word_ff[`CW_INF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_init_empty;
    @(posedge i_sys_clk) disable iff (!i_arst_n)
      clear_all |=> register_tag_word_ff == 16'hFFFF;
  endproperty
  init_empty_a: assert property (p_init_empty) else $error("tags not emptied");

  init_ptr_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    clear_all |=> last_instruction_pointer_ff == 48'h0 && last_operand_pointer_ff == 48'h0)
    else $error("pointers not cleared");

  ctrl_keep_ptr_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_valid && i_class inside {OP_STENV, OP_CTRL}) |=> $stable(last_instruction_pointer_ff))
    else $error("control instruction moved pointer");

  push_ovf_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (is_push && register_tag_word_ff[push_top*2 +: 2] != 2'h3) |=> o_overflow)
    else $error("overflow missed");

  pop_unf_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (is_pop && register_tag_word_ff[pop_top*2 +: 2] == 2'h3) |=> o_underflow)
    else $error("underflow missed");

  opc_capture_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (noncontrol && !clear_all) |=> last_opcode_record_ff == {$past(i_opc_byte1[2:0]),
                                                             $past(i_opc_byte2)})
    else $error("opcode not captured");

  ptr_together_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    $changed(last_opcode_record_ff) && !$past(env_load) && !$past(clear_all)
      |-> $past(noncontrol))
    else $error("opcode changed alone");

  load_empty_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (env_load && i_img_tag[1:0] == 2'h3) |=> register_tag_word_ff[1:0] == 2'h3)
    else $error("empty image tag not kept");

  save_flags_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    is_save |=> o_store_env && o_store_data)
    else $error("save strobes missing");

  ctrl_keep_opc_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_valid && i_class inside {OP_STENV, OP_CTRL})
      |=> $stable(last_opcode_record_ff) && $stable(last_operand_pointer_ff))
    else $error("control instruction moved opcode or operand pointer");

  no_mem_keep_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (noncontrol && !i_has_mem) |=> $stable(last_operand_pointer_ff))
    else $error("operand pointer moved without memory operand");

  arith_dst_tag_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    (i_valid && i_class == OP_ARITH && i_dst_write)
      |=> register_tag_word_ff[3'($past(i_top) + $past(i_dst_rel))*2 +: 2] == $past(i_dst_tag))
    else $error("arithmetic destination tag misplaced");

  stenv_strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
    is_stenv |=> o_store_env && !o_store_data)
    else $error("environment store strobes wrong");

  cov_push_ovf: cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) ovf_hit);
  cov_pop_unf:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) unf_hit);
  cov_reload:   cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) is_rstor);
  cov_arith:    cover property (@(posedge i_sys_clk) disable iff (!i_arst_n)
                                noncontrol && i_has_mem);
  cov_save:     cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) is_save);
endmodule

// ===== fpu_state_map.svh
`ifndef FPU_STATE_MAP_SVH
`define FPU_STATE_MAP_SVH
`define TAG_VALID        2'h0
`define TAG_ZERO         2'h1
`define TAG_SPECIAL      2'h2
`define TAG_EMPTY        2'h3
`define TAG_WORD_RESET   16'hFFFF
`define PTR_OFS_LSB      0
`define PTR_OFS_MSB      31
`define PTR_SEL_LSB      32
`define PTR_SEL_MSB      47
`define OPC_FIRST_FIXED  5'h1B
`define CW_INF_BIT       12
`define CW_INIT          16'h037F
`define EXT_EXP_MAX      15'h7FFF
`endif

// ===== fpu_state_pkg.sv
package fpu_state_pkg;
  typedef logic [1:0]  tag_t;
  typedef logic [47:0] far_ptr_t;
  typedef logic [10:0] opcode_rec_t;
  typedef logic [79:0] ext_real_t;
  typedef logic [2:0]  phys_idx_t;
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_ARITH = 4'h1,
    OP_PUSH  = 4'h2,
    OP_POP   = 4'h3,
    OP_INIT  = 4'h4,
    OP_STENV = 4'h5,
    OP_SAVE  = 4'h6,
    OP_LDENV = 4'h7,
    OP_RSTOR = 4'h8,
    OP_CTRL  = 4'h9
  } instr_class_t;
  typedef enum logic [1:0] {
    LAYOUT_PROT32 = 2'h0,
    LAYOUT_REAL32 = 2'h1,
    LAYOUT_PROT16 = 2'h2,
    LAYOUT_REAL16 = 2'h3
  } env_layout_t;
endpackage

// ===== tag_class_if.sv
`timescale 1ns/1ps
interface tag_class_if;
  import fpu_state_pkg::*;
  ext_real_t value [8];
  tag_t      tag   [8];
  modport requester (output value, input tag);
  modport classifier (input value, output tag);
endinterface

// ===== tag_classifier.sv
`timescale 1ns/1ps
`include "fpu_state_map.svh"
module tag_classifier (
  tag_class_if.classifier cls
);
  import fpu_state_pkg::*;
  function automatic tag_t classify(input ext_real_t v);
    logic [14:0] e;
    logic        j;
    logic [62:0] f;
    e = v[78:64];
    j = v[63];
    f = v[62:0];
    if (e == 15'h0000 && !j && f == 63'h0)
      classify = `TAG_ZERO;
    else if (e == 15'h0000 || e == `EXT_EXP_MAX || !j)
      classify = `TAG_SPECIAL;
    else
      classify = `TAG_VALID;
  endfunction
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_cls
      assign cls.tag[g] = classify(cls.value[g]);
    end
  endgenerate
endmodule

// ===== layout_select.sv
`timescale 1ns/1ps
module layout_select (
  // Mode inputs
  input  wire logic                       i_protected,
  input  wire logic                       i_v86,
  input  wire logic                       i_op32,
  // Selected layout
  output fpu_state_pkg::env_layout_t      o_layout
);
  import fpu_state_pkg::*;
  wire logic real_fmt;
  assign real_fmt = !i_protected || i_v86;
  assign o_layout = real_fmt ? (i_op32 ? LAYOUT_REAL32 : LAYOUT_REAL16)
                             : (i_op32 ? LAYOUT_PROT32 : LAYOUT_PROT16);
endmodule

// ===== pipe_model.sv
`timescale 1ns/1ps
module pipe_model #(
  parameter int W = 8
) (
  // Clock
  input  wire logic    i_sys_clk,
  // Completed instruction
  output logic         o_valid,
  output logic [W-1:0] o_req
);
  ////////////////////////////////////////////////////////////
  initial begin
    o_valid = 1'b0;
    o_req   = '0;
  end
  // Held from launch edge to taking edge
  task automatic issue(input logic [W-1:0] r);
    @(posedge i_sys_clk);
    o_valid <= 1'b1;
    o_req   <= r;
    @(posedge i_sys_clk);
    o_valid <= 1'b0;
    o_req   <= ~r;
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
`include "fpu_state_map.svh"
module testbench;
  import fpu_state_pkg::*;
  typedef struct packed {
    instr_class_t cls;
    logic [2:0]   top;
    logic [2:0]   sr;
    logic         su;
    logic         hm;
    far_ptr_t     ip;
    far_ptr_t     op;
    logic [7:0]   b1;
    logic [7:0]   b2;
    logic         dw;
    logic [2:0]   dr;
    tag_t         dt;
  } req_t;
  localparam int RW = $bits(req_t);
  logic         i_sys_clk, i_arst_n, valid, prot, v86, op32, inf;
  logic         ovf, unf, st_env, st_data, ld_data;
  req_t         rq, r;
  far_ptr_t     img_ip, img_op, ip_img, op_img, e_ip, e_op;
  opcode_rec_t  img_opc, opc_img, e_opc;
  logic [15:0]  img_tag, img_cw, tag_img, cw_img, e_cw;
  ext_real_t    data_reg [8];
  env_layout_t  layout;
  tag_t         e_tag [8];
  logic [2:0]   e_top;
  logic         e_ov, e_un, e_se, e_sd, e_ld, opc_ok;
  int           fail_count, checked;
  instr_class_t cls_tab [12] = '{OP_ARITH, OP_ARITH, OP_PUSH, OP_PUSH, OP_POP, OP_POP,
                                 OP_CTRL, OP_STENV, OP_LDENV, OP_RSTOR, OP_INIT, OP_SAVE};
  ////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end
  pipe_model #(.W(RW)) pipe (.i_sys_clk, .o_valid(valid), .o_req(rq));
  fpu_state_registers dut (
    .i_sys_clk, .i_arst_n, .i_valid(valid), .i_class(rq.cls), .i_top(rq.top),
    .i_src_rel(rq.sr), .i_src_used(rq.su), .i_has_mem(rq.hm), .i_instr_ptr(rq.ip),
    .i_oper_ptr(rq.op), .i_opc_byte1(rq.b1), .i_opc_byte2(rq.b2), .i_dst_write(rq.dw),
    .i_dst_rel(rq.dr), .i_dst_tag(rq.dt), .i_protected(prot), .i_v86(v86), .i_op32(op32),
    .i_img_tag(img_tag), .i_img_iptr(img_ip), .i_img_optr(img_op), .i_img_opc(img_opc),
    .i_img_cw(img_cw), .i_data_reg(data_reg), .o_overflow(ovf), .o_underflow(unf),
    .o_store_env(st_env), .o_store_data(st_data), .o_load_data(ld_data),
    .o_layout(layout), .o_tag_image(tag_img), .o_iptr_image(ip_img),
    .o_optr_image(op_img), .o_opc_image(opc_img), .o_cw_image(cw_img), .o_inf_ctrl(inf)
  );
  ////////////////////////////////////////////////////////////
  function automatic ext_real_t mk(input logic [1:0] k);
    ext_real_t v = 80'({$urandom, $urandom, $urandom});
    case (k)
      2'h0: v[78:0] = '0;
      2'h1: v[78:64] = `EXT_EXP_MAX;
      2'h2: v[78:63] = '0;
      default: begin
        v[63] = 1'b1;
        if (v[78:64] inside {15'h0, `EXT_EXP_MAX}) v[64] = ~v[64];
      end
    endcase
    return v;
  endfunction
  function automatic tag_t cls_of(input ext_real_t v);
    if (v[78:0] == '0) return `TAG_ZERO;
    if (v[78:64] == '0 || v[78:64] == `EXT_EXP_MAX || !v[63]) return `TAG_SPECIAL;
    return `TAG_VALID;
  endfunction
  function automatic req_t mkreq(input instr_class_t c);
    req_t q = req_t'(RW'({$urandom, $urandom, $urandom, $urandom, $urandom}));
    q.cls = c;
    return q;
  endfunction
  task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic check_all();
    logic [15:0] tw;
    for (int i = 0; i < 8; i++) tw[2*i +: 2] = e_tag[i];
    cmp("overflow", e_ov, ovf);
    cmp("underflow", e_un, unf);
    cmp("store_env", e_se, st_env);
    cmp("store_data", e_sd, st_data);
    cmp("load_data", e_ld, ld_data);
    cmp("tag_word", tw, tag_img);
    cmp("instr_ptr", e_ip, ip_img);
    cmp("oper_ptr", e_op, op_img);
    if (opc_ok) cmp("opcode", e_opc, opc_img);
    cmp("control_word", e_cw, cw_img);
    cmp("inf_ctrl", e_cw[`CW_INF_BIT], inf);
    cmp("layout", {~op32, v86 | ~prot}, layout);
  endtask
  task automatic step(input req_t q);
    logic [2:0] p;
    @(posedge i_sys_clk);
    {prot, v86, op32} <= 3'($urandom);
    {img_tag, img_cw, img_opc} <= 43'({$urandom, $urandom});
    {img_ip, img_op} <= 96'({$urandom, $urandom, $urandom});
    for (int i = 0; i < 8; i++) data_reg[i] <= mk(2'($urandom));
    @(negedge i_sys_clk);
    q.top = e_top;
    if (!(q.cls inside {OP_ARITH, OP_PUSH})) q.dw = 1'b0;
    if (q.cls != OP_ARITH) q.su = 1'b0;
    {e_ov, e_un, e_se, e_sd, e_ld} = '0;
    case (q.cls)
      OP_PUSH: begin
        p = e_top - 3'h1;
        e_ov = (e_tag[p] != `TAG_EMPTY);
        p = p + q.dr;
        if (!e_ov && q.dw) e_tag[p] = q.dt;
        e_top = e_top - 3'h1;
      end
      OP_POP: begin
        p = e_top + 3'h1;
        e_un = (e_tag[p] == `TAG_EMPTY);
        if (!e_un) e_tag[e_top] = `TAG_EMPTY;
        e_top = p;
      end
      OP_ARITH: begin
        p = e_top + q.sr;
        e_un = q.su && (e_tag[p] == `TAG_EMPTY);
        p = e_top + q.dr;
        if (q.dw) e_tag[p] = q.dt;
      end
      OP_INIT, OP_SAVE: begin
        e_tag = '{default: `TAG_EMPTY};
        {e_ip, e_op, e_cw, e_top, opc_ok} = {96'h0, `CW_INIT, 3'h0, 1'b0};
        e_se = (q.cls == OP_SAVE);
        e_sd = e_se;
      end
      OP_LDENV, OP_RSTOR: begin
        for (int i = 0; i < 8; i++) begin
          e_tag[i] = cls_of(data_reg[i]);
          if (img_tag[2*i +: 2] == `TAG_EMPTY) e_tag[i] = `TAG_EMPTY;
        end
        {e_ip, e_op, e_opc, e_cw, opc_ok} = {img_ip, img_op, img_opc, img_cw, 1'b1};
        e_ld = (q.cls == OP_RSTOR);
      end
      OP_STENV: e_se = 1'b1;
      default: ;
    endcase
    if (q.cls inside {OP_ARITH, OP_PUSH, OP_POP}) begin
      e_ip = q.ip;
      if (q.hm) e_op = q.op;
      {e_opc, opc_ok} = {q.b1[2:0], q.b2, 1'b1};
    end
    pipe.issue(q);
    @(negedge i_sys_clk);
    check_all();
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    fail_count++;
    finish_test();
  end
  initial begin
    i_arst_n = 1'b0;
    {prot, v86, op32, img_tag, img_cw, img_ip, img_op, img_opc} = '0;
    data_reg = '{default: '0};
    e_tag = '{default: `TAG_EMPTY};
    {e_ip, e_op, e_opc, e_cw, e_top, opc_ok} = {107'h0, `CW_INIT, 3'h0, 1'b1};
    {e_ov, e_un, e_se, e_sd, e_ld} = '0;
    fail_count = 0;
    checked = 0;
    void'($urandom(15));
    repeat (20) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    @(negedge i_sys_clk);
    check_all();
    // Fill past full, then drain past empty
    for (int i = 0; i < 18; i++) begin
      r = mkreq(i < 9 ? OP_PUSH : OP_POP);
      r.dr = 3'h0;
      r.dw = 1'b1;
      r.dt = tag_t'(i % 3);
      step(r);
    end
    // Empty source after init
    step(mkreq(OP_INIT));
    r = mkreq(OP_ARITH);
    r.su = 1'b1;
    step(r);
    for (int i = 0; i < 600; i++) step(mkreq(cls_tab[$urandom_range(11)]));
    finish_test();
  end
endmodule
